//--- gauge_pkg.sv
// Function
// - Contrast 1..120 stored on confirm
// - Normal or diagnostic layout applied on confirm
// - Normal layout hides relay indicator when de-energized
// - Diagnostic layout shows electrical values, selected unit
// - Flip screen; values hidden once saved, until exited
// - Saver alternates dark then lit each 12h
// - Saver off-then-on restarts with dark period
// - Torr, millibar or pascal unit for all
// - Sixteen gas entries, nitrogen default
// - Gauge error: filament off, latched, blocks on
// - Error clear works from any control source
// - Low-current overpressure trip, limit capped
// - High-current trip threshold fixed
// - High current: turn-on only at or below threshold
// - Discrete filament on only while grounded
// - Grounded emission input selects high current
// - Discrete degas only while filament on
// - Host control command switches via safe state
// - Switching command off turns off, on stays
// - Host control ignores discrete inputs
// - Only host reset returns to discrete control
// - Front panel control ignores discrete and host
package gauge_pkg;
   localparam longint unsigned CLK_HZ = 125_000_000;
   localparam logic [7:0] ADR_DISP = 8'h00;
   localparam logic [7:0] ADR_SETUP = 8'h04;
   localparam logic [7:0] ADR_LIMIT = 8'h08;
   localparam logic [7:0] ADR_CMD = 8'h0c;
   localparam logic [7:0] ADR_STATUS = 8'h10;
   localparam logic [6:0] CONTRAST_MIN = 7'h01;
   localparam logic [6:0] CONTRAST_MAX = 7'h78;
   localparam logic [6:0] CONTRAST_DEF = 7'h0a;
   localparam logic [1:0] UNIT_TORR = 2'h0;
   localparam logic [1:0] UNIT_PASCAL = 2'h2;
   localparam logic [3:0] GAS_N2 = 4'h0;
   localparam logic [15:0] LIMIT_MAX = 16'hf000;
   localparam logic [15:0] HI_LIMIT = 16'hd000;
   localparam int F_LAYOUT = 8;
   localparam int F_FLIP = 9;
   localparam int F_SAVER = 0;
   localparam int F_UNIT = 1;
   localparam int F_GAS = 3;
   localparam int F_FRONT = 7;
   localparam int F_CONTRAST = 0;
   localparam int S_FIL = 0;
   localparam int S_EMIS = 1;
   localparam int S_DEGAS = 2;
   localparam int S_ERR = 3;
   localparam int S_SRC = 4;
   localparam int S_LIT = 6;
   localparam int S_MENU = 7;
   localparam int S_PINS = 8;
   localparam int S_CONTRAST = 16;
   localparam int S_LAYOUT = 24;
   localparam int S_FLIP = 25;
   localparam int C_CONFIRM = 0;
   localparam int C_EXIT = 1;
   localparam int C_FIL_ON = 2;
   localparam int C_FIL_OFF = 3;
   localparam int C_EMIS_LOW = 4;
   localparam int C_EMIS_HIGH = 5;
   localparam int C_DEGAS_ON = 6;
   localparam int C_DEGAS_OFF = 7;
   localparam int C_CLEAR = 8;
   localparam longint unsigned DEBOUNCE_US = 10;
   localparam longint unsigned DEB_CYC = (DEBOUNCE_US * CLK_HZ + 999_999) / 1_000_000;
   localparam logic [10:0] DEB_LAST = 11'(DEB_CYC - 1);
   localparam longint unsigned SAVER_HOURS = 12;
   localparam longint unsigned SAVER_CYC = SAVER_HOURS * 64'd3600 * CLK_HZ;
   localparam int SAVER_W = 43;
   typedef enum logic [2:0] {
      HC_READ, HC_FIL_ON, HC_FIL_OFF, HC_DEGAS_ON,
      HC_DEGAS_OFF, HC_EMIS_LOW, HC_EMIS_HIGH, HC_RESET
   } host_cmd_t;
   typedef enum logic [1:0] {SRC_DISCRETE, SRC_SAFE, SRC_HOST} src_t;
endpackage

//--- ion_gauge_control_arbiter.sv
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
module ion_gauge_control_arbiter #(
   parameter longint unsigned SAVER_CYCLES = gauge_pkg::SAVER_CYC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic fil_enable_n_i,
   input wire logic emission_select_n_i,
   input wire logic degas_n_i,
   input wire logic host_cmd_valid_i,
   input wire logic [2:0] host_cmd_i,
   input wire logic [15:0] pressure_i,
   input wire logic emission_fail_i,
   input wire logic relay_energized_i,
   output logic filament_on_o,
   output logic emission_high_o,
   output logic degas_on_o,
   output logic gauge_error_o,
   output logic host_control_o,
   output logic [6:0] contrast_o,
   output logic diagnostic_display_layout_o,
   output logic flip_o,
   output logic values_visible_o,
   output logic setpoint_relay_indicator_o,
   output logic saver_lit_o,
   output logic [1:0] unit_o,
   output logic [3:0] gas_o
);
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] stab;
      logic [2:0][10:0] deb;
      gauge_pkg::src_t src;
      gauge_pkg::host_cmd_t pend;
      logic hfil;
      logic hemis;
      logic hdeg;
      logic pfil;
      logic pemis;
      logic pdeg;
      logic fil;
      logic emis;
      logic deg;
      logic err;
      logic [6:0] pc;
      logic pl;
      logic pf;
      logic [6:0] contrast;
      logic layout;
      logic flip;
      logic menu;
      logic saver;
      logic [1:0] unit;
      logic [3:0] gas;
      logic front;
      logic [15:0] limit;
      logic [gauge_pkg::SAVER_W-1:0] scnt;
      logic lit;
      logic vis;
      logic rly;
      logic host;
   } st_t;

   localparam logic [gauge_pkg::SAVER_W-1:0] SAVER_LAST =
      gauge_pkg::SAVER_W'(SAVER_CYCLES - 1);

   st_t q;
   st_t d;
   logic hit;
   logic wr;
   logic [31:0] cmd;
   logic [31:0] wdat;
   logic [31:0] disp_word;
   logic [31:0] setup_word;
   logic [31:0] stat_word;
   logic hctl;
   logic apply_en;
   gauge_pkg::host_cmd_t acmd;
   logic rf;
   logic re;
   logic rdg;
   logic trip;
   logic allow;

   // Byte-lane merge, shared by every writable register
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic is_control(input logic [2:0] c);
      return (c != gauge_pkg::HC_READ) && (c != gauge_pkg::HC_RESET);
   endfunction

   always_comb begin
      disp_word = '0;
      disp_word[gauge_pkg::F_CONTRAST +: 7] = q.pc;
      disp_word[gauge_pkg::F_LAYOUT] = q.pl;
      disp_word[gauge_pkg::F_FLIP] = q.pf;
      setup_word = '0;
      setup_word[gauge_pkg::F_SAVER] = q.saver;
      setup_word[gauge_pkg::F_UNIT +: 2] = q.unit;
      setup_word[gauge_pkg::F_GAS +: 4] = q.gas;
      setup_word[gauge_pkg::F_FRONT] = q.front;
      stat_word = '0;
      stat_word[gauge_pkg::S_FIL] = q.fil;
      stat_word[gauge_pkg::S_EMIS] = q.emis;
      stat_word[gauge_pkg::S_DEGAS] = q.deg;
      stat_word[gauge_pkg::S_ERR] = q.err;
      stat_word[gauge_pkg::S_SRC +: 2] = q.src;
      stat_word[gauge_pkg::S_LIT] = q.lit;
      stat_word[gauge_pkg::S_MENU] = q.menu;
      stat_word[gauge_pkg::S_PINS +: 3] = q.stab;
      stat_word[gauge_pkg::S_CONTRAST +: 7] = q.contrast;
      stat_word[gauge_pkg::S_LAYOUT] = q.layout;
      stat_word[gauge_pkg::S_FLIP] = q.flip;
   end

   always_comb begin
      d = q;
      wdat = '0;
      cmd = '0;
      acmd = gauge_pkg::HC_READ;
      apply_en = 1'b0;

      // Pins are asynchronous: two flops, then a stable count
      // Raw capture; inverted only after the second flop
      d.s1 = {degas_n_i, emission_select_n_i, fil_enable_n_i};
      d.s2 = q.s1;
      for (int i = 0; i < 3; i++) begin
         if (~q.s2[i] == q.stab[i]) begin
            d.deb[i] = '0;
         end else if (q.deb[i] == gauge_pkg::DEB_LAST) begin
            d.stab[i] = ~q.s2[i];
            d.deb[i] = '0;
         end else begin
            d.deb[i] = q.deb[i] + 11'h001;
         end
      end

      // Wishbone classic, one wait state, unmapped reads zero
      hit = wb_cyc_i & wb_stb_i & ~q.ack;
      wr = hit & wb_we_i;
      d.ack = hit;
      d.dat = '0;
      if (hit && !wb_we_i) begin
         case (wb_adr_i)
            gauge_pkg::ADR_DISP: begin
               d.dat = disp_word;
            end
            gauge_pkg::ADR_SETUP: begin
               d.dat = setup_word;
            end
            gauge_pkg::ADR_LIMIT: begin
               d.dat = {16'h0000, q.limit};
            end
            gauge_pkg::ADR_STATUS: begin
               d.dat = stat_word;
            end
            default: begin
               d.dat = '0;
            end
         endcase
      end

      if (wr && wb_adr_i == gauge_pkg::ADR_DISP) begin
         wdat = merge(disp_word, wb_dat_i, wb_sel_i);
         d.pc = wdat[gauge_pkg::F_CONTRAST +: 7];
         d.pl = wdat[gauge_pkg::F_LAYOUT];
         d.pf = wdat[gauge_pkg::F_FLIP];
         d.menu = 1'b1;
      end
      if (wr && wb_adr_i == gauge_pkg::ADR_SETUP) begin
         wdat = merge(setup_word, wb_dat_i, wb_sel_i);
         d.saver = wdat[gauge_pkg::F_SAVER];
         // Code 3 names no unit, so the old one stays
         if (wdat[gauge_pkg::F_UNIT +: 2] <= gauge_pkg::UNIT_PASCAL) begin
            d.unit = wdat[gauge_pkg::F_UNIT +: 2];
         end
         d.gas = wdat[gauge_pkg::F_GAS +: 4];
         d.front = wdat[gauge_pkg::F_FRONT];
         // Panel takes over from the current state, no jump
         if (wdat[gauge_pkg::F_FRONT] && !q.front) begin
            d.pfil = q.fil;
            d.pemis = q.emis;
            d.pdeg = q.deg;
         end
      end
      if (wr && wb_adr_i == gauge_pkg::ADR_LIMIT) begin
         wdat = merge({16'h0000, q.limit}, wb_dat_i, wb_sel_i);
         if (wdat[15:0] <= gauge_pkg::LIMIT_MAX) begin
            d.limit = wdat[15:0];
         end
      end
      if (wr && wb_adr_i == gauge_pkg::ADR_CMD) begin
         cmd = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
      end

      // Display settings
      if (cmd[gauge_pkg::C_CONFIRM]) begin
         if (q.pc >= gauge_pkg::CONTRAST_MIN && q.pc <= gauge_pkg::CONTRAST_MAX) begin
            d.contrast = q.pc;
         end
         d.layout = q.pl;
         d.flip = q.pf;
      end
      if (cmd[gauge_pkg::C_EXIT]) begin
         d.menu = 1'b0;
      end
      d.vis = ~(q.flip & q.menu);
      d.rly = relay_energized_i & ~q.layout;

      // Saver off holds the dark phase, so re-enable restarts it
      if (!q.saver) begin
         d.scnt = '0;
         d.lit = 1'b0;
      end else if (q.scnt == SAVER_LAST) begin
         d.scnt = '0;
         d.lit = ~q.lit;
      end else begin
         d.scnt = q.scnt + 1'b1;
      end

      // Control source
      hctl = host_cmd_valid_i & is_control(host_cmd_i) & ~q.front;
      case (q.src)
         gauge_pkg::SRC_DISCRETE: begin
            if (hctl) begin
               d.src = gauge_pkg::SRC_SAFE;
               d.pend = gauge_pkg::host_cmd_t'(host_cmd_i);
               d.hfil = q.fil;
               d.hemis = q.emis;
               d.hdeg = 1'b0;
            end
         end
         gauge_pkg::SRC_SAFE: begin
            d.src = gauge_pkg::SRC_HOST;
            apply_en = 1'b1;
            acmd = q.pend;
         end
         gauge_pkg::SRC_HOST: begin
            if (host_cmd_valid_i && host_cmd_i == gauge_pkg::HC_RESET) begin
               d.src = gauge_pkg::SRC_DISCRETE;
               d.hdeg = 1'b0;
            end else if (hctl) begin
               apply_en = 1'b1;
               acmd = gauge_pkg::host_cmd_t'(host_cmd_i);
            end
         end
         default: begin
            d.src = gauge_pkg::SRC_DISCRETE;
         end
      endcase
      d.host = (d.src != gauge_pkg::SRC_DISCRETE);
      if (apply_en) begin
         case (acmd)
            gauge_pkg::HC_FIL_ON: begin
               d.hfil = 1'b1;
            end
            gauge_pkg::HC_FIL_OFF: begin
               d.hfil = 1'b0;
            end
            gauge_pkg::HC_DEGAS_ON: begin
               d.hdeg = 1'b1;
            end
            gauge_pkg::HC_DEGAS_OFF: begin
               d.hdeg = 1'b0;
            end
            gauge_pkg::HC_EMIS_LOW: begin
               d.hemis = 1'b0;
            end
            gauge_pkg::HC_EMIS_HIGH: begin
               d.hemis = 1'b1;
            end
            default: begin
               d.hdeg = d.hdeg;
            end
         endcase
      end

      // Panel keys count only with front panel control
      if (q.front) begin
         if (cmd[gauge_pkg::C_FIL_ON]) begin
            d.pfil = 1'b1;
         end
         if (cmd[gauge_pkg::C_FIL_OFF]) begin
            d.pfil = 1'b0;
         end
         if (cmd[gauge_pkg::C_EMIS_LOW]) begin
            d.pemis = 1'b0;
         end
         if (cmd[gauge_pkg::C_EMIS_HIGH]) begin
            d.pemis = 1'b1;
         end
         if (cmd[gauge_pkg::C_DEGAS_ON]) begin
            d.pdeg = 1'b1;
         end
         if (cmd[gauge_pkg::C_DEGAS_OFF]) begin
            d.pdeg = 1'b0;
         end
      end

      // Request of the source in authority
      if (q.front) begin
         rf = q.pfil;
         re = q.pemis;
         rdg = q.pdeg;
      end else if (q.src == gauge_pkg::SRC_DISCRETE) begin
         rf = q.stab[0];
         re = q.stab[1];
         rdg = q.stab[2];
      end else if (q.src == gauge_pkg::SRC_SAFE) begin
         rf = q.fil;
         re = q.emis;
         rdg = 1'b0;
      end else begin
         rf = q.hfil;
         re = q.hemis;
         rdg = q.hdeg;
      end

      // Interlocks
      trip = q.fil & (emission_fail_i |
             (q.emis ? (pressure_i > gauge_pkg::HI_LIMIT)
                     : (pressure_i > q.limit)));
      // A trip in the clear cycle still latches
      d.err = trip | (q.err & ~cmd[gauge_pkg::C_CLEAR]);
      allow = ~re | (pressure_i <= gauge_pkg::HI_LIMIT);
      d.fil = rf & ~trip & ~q.err & (q.fil | allow);
      d.emis = re;
      d.deg = rdg & q.fil & d.fil;
      if (trip) begin
         d.pfil = 1'b0;
         d.hfil = 1'b0;
         d.pdeg = 1'b0;
         d.hdeg = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         q <= '0;
         q.pc <= gauge_pkg::CONTRAST_DEF;
         q.contrast <= gauge_pkg::CONTRAST_DEF;
         q.saver <= 1'b1;
         q.unit <= gauge_pkg::UNIT_TORR;
         q.gas <= gauge_pkg::GAS_N2;
         q.limit <= gauge_pkg::LIMIT_MAX;
         q.vis <= 1'b1;
         q.s1 <= '1;
         q.s2 <= '1;
      end else begin
         q <= d;
      end
   end

   assign wb_dat_o = q.dat;
   assign wb_ack_o = q.ack;
   assign filament_on_o = q.fil;
   assign emission_high_o = q.emis;
   assign degas_on_o = q.deg;
   assign gauge_error_o = q.err;
   assign host_control_o = q.host;
   assign contrast_o = q.contrast;
   assign diagnostic_display_layout_o = q.layout;
   assign flip_o = q.flip;
   assign values_visible_o = q.vis;
   assign setpoint_relay_indicator_o = q.rly;
   assign saver_lit_o = q.lit;
   assign unit_o = q.unit;
   assign gas_o = q.gas;
endmodule

//--- ion_gauge_control_arbiter_monitor.sv
`timescale 1ns/1ns
module ion_gauge_control_arbiter_monitor (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic wb_we_i,
   input wire logic host_cmd_valid_i,
   input wire logic [2:0] host_cmd_i,
   input wire logic [15:0] pressure_i,
   input wire logic emission_fail_i,
   input wire logic relay_energized_i,
   input wire logic filament_on_o,
   input wire logic emission_high_o,
   input wire logic degas_on_o,
   input wire logic gauge_error_o,
   input wire logic host_control_o,
   input wire logic [6:0] contrast_o,
   input wire logic flip_o,
   input wire logic values_visible_o,
   input wire logic setpoint_relay_indicator_o
);
   logic reset_cmd;
   logic control_cmd;
   assign reset_cmd = host_cmd_valid_i && host_cmd_i == gauge_pkg::HC_RESET;
   assign control_cmd = host_cmd_valid_i && host_cmd_i != gauge_pkg::HC_READ && !reset_cmd;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   chk_contrast_range:
      assert property (contrast_o inside {[gauge_pkg::CONTRAST_MIN:gauge_pkg::CONTRAST_MAX]})
      else $error("contrast outside its range");
   chk_relay_hidden:
      assert property (!$past(relay_energized_i) |-> !setpoint_relay_indicator_o)
      else $error("relay indicator shown while relay off");
   chk_values_shown:
      assert property (!flip_o |=> values_visible_o)
      else $error("values hidden without flip");
   chk_error_blocks:
      assert property (gauge_error_o |-> !filament_on_o)
      else $error("filament on while error latched");
   chk_fail_trips:
      assert property (filament_on_o && emission_fail_i |=> gauge_error_o && !filament_on_o)
      else $error("emission failure did not trip");
   chk_error_latched:
      assert property ($fell(gauge_error_o) |-> $past(wb_we_i) || $past(wb_we_i, 2))
      else $error("error dropped without a clear write");
   chk_high_trip:
      assert property (filament_on_o && emission_high_o && pressure_i > gauge_pkg::HI_LIMIT
         |=> !filament_on_o)
      else $error("high current trip missed");
   chk_high_turn_on:
      assert property ($rose(filament_on_o) && emission_high_o
         |-> $past(pressure_i) <= gauge_pkg::HI_LIMIT)
      else $error("high current turn-on above threshold");
   chk_degas_needs_fil:
      assert property ($rose(degas_on_o) |-> filament_on_o)
      else $error("degas started with filament off");
   chk_host_entry:
      assert property ($rose(host_control_o) |-> $past(control_cmd))
      else $error("host control without a control command");
   chk_host_exit:
      assert property ($fell(host_control_o) |-> $past(reset_cmd))
      else $error("host control left without reset");
   cover property ($rose(host_control_o));
   cover property (gauge_error_o && emission_high_o);
   cover property ($rose(degas_on_o));
endmodule

//--- plc_host_model.sv
`timescale 1ns/1ns
module plc_host_model (
   input wire logic clk_i,
   output logic fil_enable_n_o,
   output logic emission_select_n_o,
   output logic degas_n_o,
   output logic host_cmd_valid_o,
   output logic [2:0] host_cmd_o
);
   initial begin
      {fil_enable_n_o, emission_select_n_o, degas_n_o} = 3'h7;
      host_cmd_valid_o = 1'b0;
      host_cmd_o = 3'h0;
   end
   // Pins held continuously; contacts bounce before settling
   task pins(input logic f, input logic e, input logic d);
      logic [2:0] old;
      old = {fil_enable_n_o, emission_select_n_o, degas_n_o};
      repeat (4) begin
         @(posedge clk_i);
         {fil_enable_n_o, emission_select_n_o, degas_n_o} <= {~f, ~e, ~d};
         repeat (3) @(posedge clk_i);
         {fil_enable_n_o, emission_select_n_o, degas_n_o} <= old;
      end
      @(posedge clk_i);
      {fil_enable_n_o, emission_select_n_o, degas_n_o} <= {~f, ~e, ~d};
   endtask
   // Control ends only through the reset code
   task send(input logic [2:0] code);
      @(posedge clk_i);
      host_cmd_valid_o <= 1'b1;
      host_cmd_o <= code;
      @(posedge clk_i);
      host_cmd_valid_o <= 1'b0;
      host_cmd_o <= ~code;
   endtask
endmodule

//--- ion_gauge_control_arbiter_tb.sv
`timescale 1ns/1ns
module ion_gauge_control_arbiter_tb;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0;
   logic [15:0] pressure_i = 16'h0100;
   logic emission_fail_i = 1'b0;
   logic relay_energized_i = 1'b0;
   logic [31:0] wb_dat_o, rdat;
   logic wb_ack_o, fil_enable_n_i, emission_select_n_i, degas_n_i, host_cmd_valid_i;
   logic [2:0] host_cmd_i;
   logic filament_on_o, emission_high_o, degas_on_o, gauge_error_o, host_control_o;
   logic diagnostic_display_layout_o, flip_o, values_visible_o, setpoint_relay_indicator_o;
   logic saver_lit_o;
   logic [6:0] contrast_o;
   logic [1:0] unit_o;
   logic [3:0] gas_o;
   logic [6:0] c_in [4] = '{7'h78, 7'h00, 7'h79, 7'h01};
   logic [6:0] c_ex [4] = '{7'h78, 7'h78, 7'h78, 7'h01};
   logic [2:0] h_cmd [4] = '{3'h6, 3'h3, 3'h4, 3'h5};
   logic [1:0] h_ex [4] = '{2'h2, 2'h3, 2'h2, 2'h0};
   int f_bit [6] = '{5, 6, 7, 4, 3, 2};
   logic [2:0] f_ex [6] = '{3'h6, 3'h7, 3'h6, 3'h4, 3'h0, 3'h4};
   int n_mismatch = 0;
   int checks_done = 0;
   always #4 clk_i = ~clk_i;
   // Short saver period keeps the run small
   ion_gauge_control_arbiter #(.SAVER_CYCLES(20)) dut_u (.clk_i, .rst_n_i, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .fil_enable_n_i, .emission_select_n_i, .degas_n_i, .host_cmd_valid_i, .host_cmd_i,
      .pressure_i, .emission_fail_i, .relay_energized_i, .filament_on_o, .emission_high_o,
      .degas_on_o, .gauge_error_o, .host_control_o, .contrast_o, .diagnostic_display_layout_o,
      .flip_o, .values_visible_o, .setpoint_relay_indicator_o, .saver_lit_o, .unit_o, .gas_o);
   plc_host_model plc_u (.clk_i, .fil_enable_n_o(fil_enable_n_i),
      .emission_select_n_o(emission_select_n_i), .degas_n_o(degas_n_i),
      .host_cmd_valid_o(host_cmd_valid_i), .host_cmd_o(host_cmd_i));
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= (s != 4'h0);
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= (s == 4'h0) ? 4'hf : s;
      // No local limit: a hang is ended by the watchdog alone
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      wr(a, 32'h0, 4'h0);
      chk("read data", exp, rdat);
   endtask
   task cmd(input int b);
      wr(gauge_pkg::ADR_CMD, 32'h1 << b);
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task final_report();
      $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      wt(40000);
      n_mismatch++;
      final_report();
   end
   initial begin
      wt(8);
      rst_n_i <= 1'b1;
      wt(2);
      chk("reset outs", {gauge_pkg::CONTRAST_DEF, 1'b1, 2'h0, 4'h0, 2'h0}, {contrast_o,
         values_visible_o, unit_o, gas_o, filament_on_o, host_control_o});
      rd(gauge_pkg::ADR_LIMIT, 32'hf000);
      for (int i = 0; i < 4; i++) begin
         wr(gauge_pkg::ADR_DISP, {25'h0, c_in[i]});
         cmd(gauge_pkg::C_CONFIRM);
         wt(2);
         chk("contrast", c_ex[i], contrast_o);
      end
      relay_energized_i <= 1'b1;
      wr(gauge_pkg::ADR_DISP, 32'h301);
      wt(2);
      chk("layout early", 2'h0, {diagnostic_display_layout_o, flip_o});
      cmd(gauge_pkg::C_CONFIRM);
      wt(2);
      chk("layout", 4'hc, {diagnostic_display_layout_o, flip_o, values_visible_o,
         setpoint_relay_indicator_o});
      cmd(gauge_pkg::C_EXIT);
      wt(2);
      chk("visible", 1'b1, values_visible_o);
      wr(gauge_pkg::ADR_DISP, 32'h1);
      cmd(gauge_pkg::C_CONFIRM);
      wt(2);
      chk("relay shown", 1'b1, setpoint_relay_indicator_o);
      relay_energized_i <= 1'b0;
      wt(2);
      chk("relay hidden", 1'b0, setpoint_relay_indicator_o);
      for (int i = 0; i < 16; i++) begin
         wr(gauge_pkg::ADR_SETUP, 32'(i * 8 + (i % 3) * 2 + 1));
         wt(2);
         chk("unit gas", 32'((i % 3) * 16 + i), {unit_o, gas_o});
      end
      wr(gauge_pkg::ADR_SETUP, 32'h5);
      wr(gauge_pkg::ADR_SETUP, 32'h7);
      wt(2);
      chk("bad unit", 2'h2, unit_o);
      rd(8'h14, 32'h0);
      wr(gauge_pkg::ADR_SETUP, 32'h0);
      wt(2);
      chk("saver off", 1'b0, saver_lit_o);
      wr(gauge_pkg::ADR_SETUP, 32'h1);
      wt(10);
      chk("saver dark", 1'b0, saver_lit_o);
      wt(20);
      chk("saver lit", 1'b1, saver_lit_o);
      wt(20);
      chk("saver dark2", 1'b0, saver_lit_o);
      plc_u.pins(1'b0, 1'b0, 1'b1);
      wt(1300);
      chk("degas alone", 1'b0, degas_on_o);
      plc_u.pins(1'b1, 1'b0, 1'b1);
      wt(100);
      chk("bounce", 1'b0, filament_on_o);
      wt(1200);
      chk("fil degas", 2'h3, {filament_on_o, degas_on_o});
      plc_u.pins(1'b1, 1'b1, 1'b0);
      wt(1300);
      chk("emis high", 1'b1, emission_high_o);
      pressure_i <= 16'hd001;
      wt(3);
      chk("high trip", 2'h2, {gauge_error_o, filament_on_o});
      cmd(gauge_pkg::C_CLEAR);
      wt(4);
      chk("high block", 2'h0, {gauge_error_o, filament_on_o});
      pressure_i <= 16'hd000;
      wt(4);
      chk("high on", 1'b1, filament_on_o);
      emission_fail_i <= 1'b1;
      wt(2);
      emission_fail_i <= 1'b0;
      wt(6);
      chk("fail latch", 2'h2, {gauge_error_o, filament_on_o});
      cmd(gauge_pkg::C_CLEAR);
      wt(4);
      chk("cleared", 2'h1, {gauge_error_o, filament_on_o});
      pressure_i <= 16'h0100;
      plc_u.pins(1'b1, 1'b0, 1'b0);
      wt(1300);
      wr(gauge_pkg::ADR_LIMIT, 32'h1000);
      wr(gauge_pkg::ADR_LIMIT, 32'hf001);
      rd(gauge_pkg::ADR_LIMIT, 32'h1000);
      wr(gauge_pkg::ADR_LIMIT, 32'h2255, 4'h1);
      rd(gauge_pkg::ADR_LIMIT, 32'h1055);
      pressure_i <= 16'h1056;
      wt(3);
      chk("low trip", 2'h2, {gauge_error_o, filament_on_o});
      pressure_i <= 16'h0100;
      cmd(gauge_pkg::C_CLEAR);
      wt(4);
      plc_u.send(gauge_pkg::HC_READ);
      wt(3);
      chk("read cmd", 2'h1, {host_control_o, filament_on_o});
      plc_u.send(gauge_pkg::HC_FIL_OFF);
      wt(8);
      chk("host off", 2'h2, {host_control_o, filament_on_o});
      plc_u.send(gauge_pkg::HC_FIL_ON);
      wt(4);
      for (int i = 0; i < 4; i++) begin
         plc_u.send(h_cmd[i]);
         wt(4);
         chk("host emis degas", h_ex[i], {emission_high_o, degas_on_o});
      end
      plc_u.pins(1'b0, 1'b0, 1'b0);
      wt(1300);
      chk("pins ignored", 1'b1, filament_on_o);
      plc_u.send(gauge_pkg::HC_RESET);
      wt(3);
      chk("host reset", 1'b0, host_control_o);
      plc_u.pins(1'b1, 1'b0, 1'b0);
      wt(1300);
      plc_u.send(gauge_pkg::HC_FIL_ON);
      repeat (4) begin
         @(posedge clk_i);
         chk("switch on", 1'b1, filament_on_o);
      end
      plc_u.send(gauge_pkg::HC_RESET);
      wt(3);
      wr(gauge_pkg::ADR_SETUP, 32'h81);
      plc_u.send(gauge_pkg::HC_FIL_OFF);
      plc_u.pins(1'b0, 1'b0, 1'b0);
      wt(1300);
      chk("front holds", 2'h1, {host_control_o, filament_on_o});
      for (int i = 0; i < 6; i++) begin
         cmd(f_bit[i]);
         wt(3);
         chk("front keys", f_ex[i], {filament_on_o, emission_high_o, degas_on_o});
      end
      final_report();
   end
endmodule
bind ion_gauge_control_arbiter ion_gauge_control_arbiter_monitor mon_u (.clk_i, .rst_n_i,
   .wb_we_i, .host_cmd_valid_i, .host_cmd_i, .pressure_i, .emission_fail_i,
   .relay_energized_i, .filament_on_o, .emission_high_o, .degas_on_o, .gauge_error_o,
   .host_control_o, .contrast_o, .flip_o, .values_visible_o, .setpoint_relay_indicator_o);
